// file: hdl/srxrc_defs.svh
/*
 * Constants for the receive reset and mode control block: timing counts,
 * config-port addresses, bit positions and attribute values.
 * Assumes a 10 MHz system clock and a 16-bit config port.
 */
// Notes on behaviour
// - After reset or full request, reset receive PLL, then the receiver.
// - Each receiver reset clears bit 11 at address 0x011, then restores it.
// - That config bit reads 1 during normal receive operation.
// - Recovery hold high in SD mode, low in HD and 3G.
// - Equalizer adaptation off in SD, on in HD and 3G.
// - Entering HD or 3G rewrites the recovery config attribute.
// - Recovery config and receive divider written through config port.
// - One receiver reset after all mode setting changes.
// - Full request resets PLL first; receiver waits for PLL lock.
// - Receive-only request resets receiver; completion waits for lock.
// - Shared-source parameter picks receive divider value.
// - Transmit select chooses low or high source parameter and divider.
// - Stable input low never starts a reset, only delays completion.
`ifndef SRXRC_DEFS_SVH
`define SRXRC_DEFS_SVH

`define SRXRC_PLL_RST_NS     500
`define SRXRC_RX_RST_NS      500
`define SRXRC_CLK_NS         100
`define SRXRC_CEIL(ns)       (((ns) + `SRXRC_CLK_NS - 1) / `SRXRC_CLK_NS)

`define SRXRC_ADDR_RESET     9'h011
`define SRXRC_RESET_BIT      11
`define SRXRC_ADDR_CDR       9'h0A8
`define SRXRC_ADDR_DIV       9'h088
`define SRXRC_DIV_LSB        0

`define SRXRC_CDR_SD         16'h0000
`define SRXRC_CDR_HD         16'h0010
`define SRXRC_CDR_3G         16'h0020

`define SRXRC_DIV_SD         3'h0
`define SRXRC_DIV_HD         3'h2
`define SRXRC_DIV_3G         3'h1

`define SRXRC_MODE_HD        2'h0
`define SRXRC_MODE_SD        2'h1
`define SRXRC_MODE_3G        2'h2

`define SRXRC_SEL_LOCAL      2'h0
`define SRXRC_SEL_SHARED     2'h3

`endif

// file: hdl/srxrc_pkg.sv
/*
 * Types for the receive reset and mode control block.
 * Assumes srxrc_defs.svh is compiled alongside.
 */
package srxrc_pkg;

	typedef enum logic [11:0] {
		ST_IDLE     = 12'b0000_0000_0001,
		ST_PLL_RST  = 12'b0000_0000_0010,
		ST_PLL_WAIT = 12'b0000_0000_0100,
		ST_RD_RST   = 12'b0000_0000_1000,
		ST_WR_CLR   = 12'b0000_0001_0000,
		ST_RX_RST   = 12'b0000_0010_0000,
		ST_LOCK     = 12'b0000_0100_0000,
		ST_WR_SET   = 12'b0000_1000_0000,
		ST_DONE     = 12'b0001_0000_0000,
		ST_WR_CDR   = 12'b0010_0000_0000,
		ST_RD_DIV   = 12'b0100_0000_0000,
		ST_WR_DIV   = 12'b1000_0000_0000
	} srxrc_state_e;

	typedef struct packed {
		logic        en;
		logic        we;
		logic [8:0]  addr;
		logic [15:0] di;
	} srxrc_cfg_req_s;

	typedef struct packed {
		logic        rdy;
		logic [15:0] dout;
	} srxrc_cfg_rsp_s;

endpackage : srxrc_pkg

// file: hdl/srxrc_timer.sv
/*
 * Down-counting delay timer; done pulses one cycle after the count runs out.
 * Assumes a start pulse loads the count; restart is allowed at any time.
 */
`timescale 1ns/1ps
module srxrc_timer #(
	parameter int W = 8
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic         start_i,
	input  wire logic [W-1:0] count_i,
	output logic              done_o
);
	logic [W-1:0] cnt_q;
	logic         run_q;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_q  <= '0;
			run_q  <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				cnt_q <= count_i;
				run_q <= 1'b1;
			end else if (run_q) begin
				if (cnt_q <= W'(1)) begin
					run_q  <= 1'b0;
					done_o <= 1'b1;
				end else begin
					cnt_q <= cnt_q - W'(1);
				end
			end
		end
	end
endmodule : srxrc_timer

// file: hdl/srxrc_top.sv
/*
 * Receive reset and mode sequencer for a serial transceiver in SDI use:
 * PLL reset, receiver reset with config-bit dance, mode settings.
 * Assumes inputs are synchronous to CLK_SYS_I and a ready-pulsed config port.
 */
`timescale 1ns/1ps
`include "srxrc_defs.svh"
module srxrc_top
	import srxrc_pkg::*;
#(
	parameter int RECEIVE_SOURCE_IS_SHARED     = 1,
	parameter int TRANSMIT_SOURCE_LOW_SELECT   = 1,
	parameter int TRANSMIT_SOURCE_HIGH_SELECT  = 0
) (
	input  wire logic        CLK_SYS_I,
	input  wire logic        NRST_I,
	input  wire logic        RX_FULL_RESET_I,
	input  wire logic        RX_RESET_I,
	input  wire logic        RX_DP_RESET_I,
	input  wire logic [1:0]  RX_MODE_I,
	input  wire logic        RX_PLL_LOCK_I,
	input  wire logic        RX_REFCLK_STABLE_I,
	input  wire logic        RX_RESET_DONE_I,
	input  wire logic        TX_RATE_SEL_I,
	input  wire logic        CFG_RDY_I,
	input  wire logic [15:0] CFG_DOUT_I,
	output logic             RX_PLL_RESET_O,
	output logic             RX_RESET_O,
	output logic             RX_DP_RESET_O,
	output logic             RX_CDR_HOLD_O,
	output logic             RX_EQ_ADAPT_O,
	output logic             RX_BUSY_O,
	output logic             RX_CHANGE_DONE_O,
	output logic [1:0]       TX_CLK_SEL_O,
	output logic [2:0]       TX_DIV_O,
	output logic             CFG_EN_O,
	output logic             CFG_WE_O,
	output logic [8:0]       CFG_ADDR_O,
	output logic [15:0]      CFG_DI_O
);
	localparam logic [7:0] PLL_CYC = 8'(`SRXRC_CEIL(`SRXRC_PLL_RST_NS));
	localparam logic [7:0] RX_CYC  = 8'(`SRXRC_CEIL(`SRXRC_RX_RST_NS));

	srxrc_state_e   st_q;
	srxrc_cfg_req_s req_q;
	logic [15:0]    save_q;
	logic [1:0]     mode_q;
	logic           full_pend_q;
	logic           rx_pend_q;
	logic           mode_pend_q;
	logic           wait_q;
	logic           t_start_q;
	logic [7:0]     t_count_q;
	logic           t_done;
	logic           accepted;

	// Divider value for a mode, doubled rate on the local PLL except in SD
	function automatic logic [2:0] div_for(input logic [1:0] m,
		input int shared);
		logic [2:0] d;
		d = (m == `SRXRC_MODE_SD) ? `SRXRC_DIV_SD :
		    (m == `SRXRC_MODE_3G) ? `SRXRC_DIV_3G : `SRXRC_DIV_HD;
		if (shared == 0 && d != 3'h0)
			d = d - 3'h1;
		return d;
	endfunction : div_for

	function automatic logic [15:0] cdr_for(input logic [1:0] m);
		return (m == `SRXRC_MODE_SD) ? `SRXRC_CDR_SD :
		       (m == `SRXRC_MODE_3G) ? `SRXRC_CDR_3G : `SRXRC_CDR_HD;
	endfunction : cdr_for

	srxrc_timer #(
		.W(8)
	) u_timer (
		.clk_i  (CLK_SYS_I),
		.nrst_i (NRST_I),
		.start_i(t_start_q),
		.count_i(t_count_q),
		.done_o (t_done)
	);

	assign accepted = (st_q == ST_IDLE);

	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			full_pend_q <= 1'b1;
			rx_pend_q   <= 1'b0;
			mode_pend_q <= 1'b0;
		end else begin
			if (RX_FULL_RESET_I)
				full_pend_q <= 1'b1;
			else if (accepted && full_pend_q)
				full_pend_q <= 1'b0;
			if (RX_RESET_I)
				rx_pend_q <= 1'b1;
			else if (accepted && !full_pend_q && rx_pend_q)
				rx_pend_q <= 1'b0;
			if (RX_MODE_I != mode_q && accepted && !full_pend_q
			    && !rx_pend_q)
				mode_pend_q <= 1'b1;
			else if (st_q == ST_WR_CDR)
				mode_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			st_q           <= ST_IDLE;
			req_q          <= '0;
			save_q         <= '0;
			mode_q         <= `SRXRC_MODE_HD;
			wait_q         <= 1'b0;
			t_start_q      <= 1'b0;
			t_count_q      <= '0;
			RX_PLL_RESET_O <= 1'b0;
			RX_RESET_O     <= 1'b0;
		end else begin
			t_start_q <= 1'b0;
			req_q.en  <= 1'b0;
			case (st_q)
			ST_IDLE: begin
				if (full_pend_q) begin
					RX_PLL_RESET_O <= 1'b1;
					t_count_q      <= PLL_CYC;
					t_start_q      <= 1'b1;
					st_q           <= ST_PLL_RST;
				end else if (rx_pend_q) begin
					st_q <= ST_RD_RST;
				end else if (mode_pend_q) begin
					mode_q <= RX_MODE_I;
					st_q   <= ST_WR_CDR;
				end
			end
			ST_PLL_RST: begin
				if (wait_q && RX_REFCLK_STABLE_I) begin
					RX_PLL_RESET_O <= 1'b0;
					wait_q         <= 1'b0;
					st_q           <= ST_PLL_WAIT;
				end else if (t_done) begin
					wait_q <= 1'b1;
				end
			end
			ST_PLL_WAIT: begin
				if (RX_PLL_LOCK_I)
					st_q <= ST_RD_RST;
			end
			ST_WR_CDR: begin
				req_q <= '{en: 1'b1, we: 1'b1, addr: `SRXRC_ADDR_CDR,
				           di: cdr_for(mode_q)};
				st_q  <= ST_RD_DIV;
			end
			ST_RD_DIV: begin
				if (CFG_RDY_I) begin
					req_q <= '{en: 1'b1, we: 1'b0, addr: `SRXRC_ADDR_DIV,
					           di: 16'h0000};
					st_q  <= ST_WR_DIV;
					wait_q <= 1'b1;
				end
			end
			ST_WR_DIV: begin
				if (CFG_RDY_I && wait_q) begin
					wait_q <= 1'b0;
					req_q  <= '{en: 1'b1, we: 1'b1, addr: `SRXRC_ADDR_DIV,
					  di: {CFG_DOUT_I[15:3],
					  div_for(mode_q, RECEIVE_SOURCE_IS_SHARED)}};
				end else if (CFG_RDY_I) begin
					st_q <= ST_RD_RST;
				end
			end
			ST_RD_RST: begin
				req_q <= '{en: 1'b1, we: 1'b0, addr: `SRXRC_ADDR_RESET,
				           di: 16'h0000};
				st_q  <= ST_WR_CLR;
			end
			ST_WR_CLR: begin
				if (CFG_RDY_I) begin
					save_q <= CFG_DOUT_I;
					req_q  <= '{en: 1'b1, we: 1'b1, addr: `SRXRC_ADDR_RESET,
					  di: CFG_DOUT_I & ~(16'h0001 << `SRXRC_RESET_BIT)};
					RX_RESET_O <= 1'b1;
					t_count_q  <= RX_CYC;
					t_start_q  <= 1'b1;
					st_q       <= ST_RX_RST;
				end
			end
			ST_RX_RST: begin
				if (t_done) begin
					RX_RESET_O <= 1'b0;
					st_q       <= ST_LOCK;
				end
			end
			ST_LOCK: begin
				if (RX_PLL_LOCK_I && RX_RESET_DONE_I) begin
					req_q <= '{en: 1'b1, we: 1'b1, addr: `SRXRC_ADDR_RESET,
					  di: save_q | (16'h0001 << `SRXRC_RESET_BIT)};
					st_q  <= ST_WR_SET;
				end
			end
			ST_WR_SET: begin
				if (CFG_RDY_I)
					st_q <= ST_DONE;
			end
			ST_DONE: begin
				st_q <= ST_IDLE;
			end
			default: begin
				st_q <= ST_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			CFG_EN_O   <= 1'b0;
			CFG_WE_O   <= 1'b0;
			CFG_ADDR_O <= '0;
			CFG_DI_O   <= '0;
		end else begin
			CFG_EN_O   <= req_q.en;
			CFG_WE_O   <= req_q.we;
			CFG_ADDR_O <= req_q.addr;
			CFG_DI_O   <= req_q.di;
		end
	end

	// Mode ports follow the latched mode
	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			RX_CDR_HOLD_O    <= 1'b0;
			RX_EQ_ADAPT_O    <= 1'b1;
			RX_BUSY_O        <= 1'b1;
			RX_CHANGE_DONE_O <= 1'b0;
			RX_DP_RESET_O    <= 1'b0;
		end else begin
			RX_CDR_HOLD_O    <= (mode_q == `SRXRC_MODE_SD);
			RX_EQ_ADAPT_O    <= (mode_q != `SRXRC_MODE_SD);
			RX_BUSY_O        <= !accepted || full_pend_q || rx_pend_q
			                    || mode_pend_q;
			RX_CHANGE_DONE_O <= (st_q == ST_DONE);
			RX_DP_RESET_O    <= RX_DP_RESET_I;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			TX_CLK_SEL_O <= `SRXRC_SEL_LOCAL;
			TX_DIV_O     <= '0;
		end else begin
			if ((TX_RATE_SEL_I ? TRANSMIT_SOURCE_HIGH_SELECT
			                   : TRANSMIT_SOURCE_LOW_SELECT) != 0)
				TX_CLK_SEL_O <= `SRXRC_SEL_SHARED;
			else
				TX_CLK_SEL_O <= `SRXRC_SEL_LOCAL;
			TX_DIV_O <= div_for(`SRXRC_MODE_HD, TX_RATE_SEL_I ?
			  TRANSMIT_SOURCE_HIGH_SELECT : TRANSMIT_SOURCE_LOW_SELECT);
		end
	end
endmodule : srxrc_top

// file: dv/srxrc_xcvr_model.sv
/* Transceiver model: config port, PLL lock and receiver reset done.
 * Assumes synchronous use on the system clock. */
`timescale 1ns/1ps
module srxrc_xcvr_model
	import srxrc_pkg::*;
#(
	parameter int LAT = 3
) (
	input  wire logic           clk_i,
	input  wire srxrc_cfg_req_s req_i,
	input  wire logic           pll_rst_i,
	input  wire logic           rx_rst_i,
	input  wire logic           unlock_i,
	output srxrc_cfg_rsp_s      rsp_o,
	output logic                lock_o,
	output logic                done_o
);
	logic [15:0] mem [0:511];
	logic [3:0]  ct_q = 4'h0;
	logic [3:0]  lk_q = 4'h0;
	logic [3:0]  dn_q = 4'h0;
	logic [8:0]  ad_q = 9'h000;
	initial begin
		rsp_o = '0;
		foreach (mem[i]) mem[i] = 16'hffff;
	end
	always @(posedge clk_i) begin
		rsp_o.rdy  <= (ct_q == 4'h1);
		rsp_o.dout <= (ct_q == 4'h1) ? mem[ad_q] : ~rsp_o.dout;
		ct_q       <= (ct_q != 4'h0) ? ct_q - 4'h1 : 4'h0;
		if (req_i.en) begin
			ct_q <= 4'(LAT);
			ad_q <= req_i.addr;
			if (req_i.we)
				mem[req_i.addr] <= req_i.di;
		end
		lk_q <= pll_rst_i ? 4'h0 : (lk_q < 4'h8 ? lk_q + 4'h1 : lk_q);
		dn_q <= rx_rst_i ? 4'h0 : (dn_q < 4'h8 ? dn_q + 4'h1 : dn_q);
	end
	assign lock_o = (lk_q == 4'h8) && !unlock_i;
	assign done_o = (dn_q == 4'h8);
endmodule : srxrc_xcvr_model

// file: dv/srxrc_top_asserts.sv
/* Port checker for srxrc_top.
 * Assumes binding to every instance of it. */
`timescale 1ns/1ps
`include "srxrc_defs.svh"
module srxrc_top_asserts #(
	parameter int TRANSMIT_SOURCE_LOW_SELECT  = 1,
	parameter int TRANSMIT_SOURCE_HIGH_SELECT = 0
) (
	input wire logic        CLK_SYS_I,
	input wire logic        NRST_I,
	input wire logic        RX_FULL_RESET_I,
	input wire logic [1:0]  RX_MODE_I,
	input wire logic        RX_PLL_LOCK_I,
	input wire logic        RX_REFCLK_STABLE_I,
	input wire logic        TX_RATE_SEL_I,
	input wire logic        CFG_RDY_I,
	input wire logic        RX_PLL_RESET_O,
	input wire logic        RX_RESET_O,
	input wire logic        RX_CDR_HOLD_O,
	input wire logic        RX_BUSY_O,
	input wire logic        RX_CHANGE_DONE_O,
	input wire logic [1:0]  TX_CLK_SEL_O,
	input wire logic        CFG_EN_O,
	input wire logic        CFG_WE_O,
	input wire logic [8:0]  CFG_ADDR_O,
	input wire logic [15:0] CFG_DI_O
);
	localparam logic [1:0] LO = TRANSMIT_SOURCE_LOW_SELECT == 1 ?
		`SRXRC_SEL_SHARED : `SRXRC_SEL_LOCAL;
	localparam logic [1:0] HI = TRANSMIT_SOURCE_HIGH_SELECT == 1 ?
		`SRXRC_SEL_SHARED : `SRXRC_SEL_LOCAL;
	logic open_q;
	logic bit_q;
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!NRST_I);
	// Config access outstanding
	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I)
			open_q <= 1'b0;
		else
			open_q <= (open_q || CFG_EN_O) && !CFG_RDY_I;
	end
	// Last written value of the reset bit
	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I)
			bit_q <= 1'b1;
		else if (CFG_EN_O && CFG_WE_O && CFG_ADDR_O == `SRXRC_ADDR_RESET)
			bit_q <= CFG_DI_O[`SRXRC_RESET_BIT];
	end
	a_pll_min: assert property (
		$rose(RX_PLL_RESET_O) |-> RX_PLL_RESET_O [*5])
		else $error("PLL reset too short");
	a_pll_held: assert property (
		RX_PLL_RESET_O && !RX_REFCLK_STABLE_I |=> RX_PLL_RESET_O)
		else $error("PLL reset released while unstable");
	a_pll_cause: assert property (
		$rose(RX_PLL_RESET_O) |-> $past(RX_BUSY_O) || $past(RX_FULL_RESET_I)
		|| $past(RX_FULL_RESET_I, 2) || $past(RX_FULL_RESET_I, 3))
		else $error("PLL reset without request");
	a_rx_after_pll: assert property (
		RX_RESET_O |-> !RX_PLL_RESET_O)
		else $error("receiver reset overlaps PLL reset");
	a_done_clean: assert property (
		RX_CHANGE_DONE_O |-> RX_PLL_LOCK_I && bit_q && !RX_RESET_O)
		else $error("done before lock or restore");
	a_bit_cleared: assert property (
		$fell(RX_RESET_O) |-> !bit_q)
		else $error("reset bit not cleared");
	a_cfg_serial: assert property (
		CFG_EN_O |-> !open_q)
		else $error("config access overlaps");
	a_hold_mode: assert property (
		RX_CHANGE_DONE_O |-> RX_CDR_HOLD_O == (RX_MODE_I == `SRXRC_MODE_SD))
		else $error("recovery hold wrong for mode");
	a_tx_sel: assert property (
		$past(NRST_I) |-> TX_CLK_SEL_O == ($past(TX_RATE_SEL_I) ? HI : LO))
		else $error("transmit source select wrong");
endmodule : srxrc_top_asserts
bind srxrc_top srxrc_top_asserts #(
	.TRANSMIT_SOURCE_LOW_SELECT(TRANSMIT_SOURCE_LOW_SELECT),
	.TRANSMIT_SOURCE_HIGH_SELECT(TRANSMIT_SOURCE_HIGH_SELECT)
) u_asserts (.*);

// file: dv/srxrc_top_tb.sv
/* Self-checking bench for srxrc_top.
 * Assumes the transceiver model and bound checker. */
`timescale 1ns/1ps
`include "srxrc_defs.svh"
module srxrc_top_tb
	import srxrc_pkg::*;
;
	logic clk = 1'b0, nrst = 1'b0, full = 1'b0, rxr = 1'b0, dpr = 1'b0;
	logic unlock = 1'b0, stable = 1'b1, rsel = 1'b0;
	logic [1:0] mode = `SRXRC_MODE_HD;
	logic lock, rdone, pllr, rxro, dpo, hold, eq, busy, cdone;
	logic [1:0] tsel;
	logic [2:0] tdiv;
	logic cen, cwe;
	logic [8:0] caddr;
	logic [15:0] cdi;
	srxrc_cfg_req_s req;
	wire srxrc_cfg_rsp_s rsp;
	int fail_count = 0, samples_checked = 0, rx_n = 0, pll_n = 0;
	srxrc_top u_dut (.CLK_SYS_I(clk), .NRST_I(nrst), .RX_FULL_RESET_I(full),
		.RX_RESET_I(rxr), .RX_DP_RESET_I(dpr), .RX_MODE_I(mode),
		.RX_PLL_LOCK_I(lock), .RX_REFCLK_STABLE_I(stable),
		.RX_RESET_DONE_I(rdone), .TX_RATE_SEL_I(rsel), .CFG_RDY_I(rsp.rdy),
		.CFG_DOUT_I(rsp.dout), .RX_PLL_RESET_O(pllr), .RX_RESET_O(rxro),
		.RX_DP_RESET_O(dpo), .RX_CDR_HOLD_O(hold), .RX_EQ_ADAPT_O(eq),
		.RX_BUSY_O(busy), .RX_CHANGE_DONE_O(cdone), .TX_CLK_SEL_O(tsel),
		.TX_DIV_O(tdiv), .CFG_EN_O(cen), .CFG_WE_O(cwe),
		.CFG_ADDR_O(caddr), .CFG_DI_O(cdi));
	assign req = {cen, cwe, caddr, cdi};
	srxrc_xcvr_model u_xcvr (.clk_i(clk), .req_i(req), .pll_rst_i(pllr),
		.rx_rst_i(rxro), .unlock_i(unlock), .rsp_o(rsp), .lock_o(lock),
		.done_o(rdone));
	initial forever #50 clk = ~clk;
	always @(posedge pllr) pll_n++;
	always @(posedge rxro) rx_n++;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
			if (n > 400) begin
				fail_count++;
				$display("[FAIL] %0t no completion", $time);
				complete_run();
			end
		end while (cdone !== 1'b1);
	endtask : wait_done
	task automatic s_init();
		wait_done();
		check(16'(pll_n), 16'h0001);
		check(16'(rx_n), 16'h0001);
		check(u_xcvr.mem[`SRXRC_ADDR_RESET][11], 1'h1);
		check({hold, eq}, 2'h1);
	endtask : s_init
	task automatic s_full();
		@(posedge clk) stable <= 1'b0;
		repeat (10) @(posedge clk);
		check(16'(pll_n), 16'h0001);
		full <= 1'b1;
		@(posedge clk) full <= 1'b0;
		repeat (30) @(posedge clk);
		#1 check(pllr, 1'h1);
		check(16'(rx_n), 16'h0001);
		@(posedge clk) stable <= 1'b1;
		wait_done();
		check(16'(pll_n), 16'h0002);
		check(16'(rx_n), 16'h0002);
	endtask : s_full
	task automatic s_rx_only();
		@(posedge clk) unlock <= 1'b1;
		rxr <= 1'b1;
		@(posedge clk) rxr <= 1'b0;
		repeat (40) @(posedge clk);
		#1 check(busy, 1'h1);
		@(posedge clk) unlock <= 1'b0;
		wait_done();
		check(16'(pll_n), 16'h0002);
		check(16'(rx_n), 16'h0003);
	endtask : s_rx_only
	task automatic s_modes();
		logic [1:0] m [4] = '{`SRXRC_MODE_SD, `SRXRC_MODE_3G,
			`SRXRC_MODE_HD, 2'h3};
		logic [15:0] c [4] = '{`SRXRC_CDR_SD, `SRXRC_CDR_3G,
			`SRXRC_CDR_HD, `SRXRC_CDR_HD};
		logic [2:0] d [4] = '{`SRXRC_DIV_SD, `SRXRC_DIV_3G,
			`SRXRC_DIV_HD, `SRXRC_DIV_HD};
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) mode <= m[i];
			wait_done();
			check(16'(rx_n), 16'(4 + i));
			check({hold, eq}, {i == 0, i != 0});
			check(u_xcvr.mem[`SRXRC_ADDR_CDR], c[i]);
			check(u_xcvr.mem[`SRXRC_ADDR_DIV], {13'h1fff, d[i]});
		end
	endtask : s_modes
	task automatic s_misc();
		@(posedge clk) dpr <= 1'b1;
		@(posedge clk) dpr <= 1'b0;
		#1 check({dpo, busy, rxro}, 3'h4);
		for (int r = 0; r < 2; r++) begin
			@(posedge clk) rsel <= r[0];
			@(posedge clk);
			#1 check({tsel, tdiv}, r ? {`SRXRC_SEL_LOCAL, 3'h1} :
				{`SRXRC_SEL_SHARED, `SRXRC_DIV_HD});
		end
	endtask : s_misc
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		s_init();
		s_full();
		s_rx_only();
		s_modes();
		s_misc();
		complete_run();
	end
endmodule : srxrc_top_tb
